// ### logic/irq_ctrl_pkg.sv
// Constants, register map and helpers shared by the interrupt controller files.
// What this block does
// R1: Twenty-two interrupt sources, four from external pins, each masked on its own.
// R2: One bit map: bit 0 fast OR, bit 1 software, bits 2 to 21 sources.
// R3: External pins sit on bits 13, 16, 18, 19; logic-array requests on 17, 20.
// R4: Normal status is raw AND enable, read-only; its OR drives the normal request.
// R5: No priority encoding or vector generation; software decodes the status register.
// R6: Normal raw bit follows the source request and clears only when the source clears.
// R7: Writing one sets a normal enable bit; writing zero leaves it unchanged.
// R8: Normal mask-clear write clears each enable bit written as one, others untouched.
// R9: Fast path has raw, enable, mask-clear and status registers like the normal path.
// R10: OR of fast status bits 31 to 1 drives fast request and bit 0 of both sets.
// R11: Setting an enable bit in one set clears the same bit in the other set.
// R12: Fast raw bit follows the source request level and clears with the source.
// R13: Nesting up to eight levels, active only while the nesting enable bit is set.
// R14: Service software should capture the status registers on entry to the handler.
// R15: Software interrupt bits drive bit 1 of the raw registers directly; status bit 1 also needs enable bit 1.
// R16: Fast mask-clear write clears each fast enable bit written as one.
// R17: A request must stay asserted for the latency time to be seen.
// R18: Unused bits 22 to 31 read zero; status updates on the edge after a change.
package irq_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [31:0] NORM_STATUS_ADR = 32'hffff0000;
    localparam logic [31:0] NORM_RAW_ADR = 32'hffff0004;
    localparam logic [31:0] NORM_ENABLE_ADR = 32'hffff0008;
    localparam logic [31:0] NORM_CLEAR_ADR = 32'hffff000c;
    localparam logic [31:0] FAST_STATUS_ADR = 32'hffff0100;
    localparam logic [31:0] FAST_RAW_ADR = 32'hffff0104;
    localparam logic [31:0] FAST_ENABLE_ADR = 32'hffff0108;
    localparam logic [31:0] FAST_CLEAR_ADR = 32'hffff010c;
    localparam logic [31:0] SWI_CONFIG_ADR = 32'hffff0110;
    localparam logic [31:0] VEC_CONTROL_ADR = 32'hffff0114;
    localparam logic [31:0] EVENT_STATUS_ADR = 32'hffff0118;
    localparam logic [31:0] EVENT_MASK_ADR = 32'hffff011c;

    // ------------------------------------------------------------------
    // Source map
    // ------------------------------------------------------------------
    localparam int SRC_COUNT = 22;
    localparam int ONCHIP_COUNT = 16;
    localparam int PIN_COUNT = 4;
    localparam logic [31:0] USED_MASK = 32'h003fffff;
    localparam int FAST_OR_BIT = 0;
    localparam int SWI_BIT = 1;
    localparam int ONCHIP_BIT [ONCHIP_COUNT] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15, 17, 20, 21};
    localparam int PIN_BIT [PIN_COUNT] = '{13, 16, 18, 19};

    // ------------------------------------------------------------------
    // Software interrupt and vectored control fields
    // ------------------------------------------------------------------
    localparam int SWI_NORM_POS = 1;
    localparam int SWI_FAST_POS = 2;
    localparam logic [31:0] SWI_MASK = 32'h00000006;
    localparam int NEST_EN_POS = 0;
    localparam int FAST_VEC_EN_POS = 1;
    localparam logic [31:0] VEC_CTL_MASK = 32'h00000003;
    localparam int NEST_DEPTH_LSB = 8;
    localparam int NEST_LEVELS = 8;
    localparam logic [3:0] NEST_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Event status fields
    // ------------------------------------------------------------------
    localparam int EV_NORM_RISE = 0;
    localparam int EV_FAST_RISE = 1;
    localparam int EV_NEST_OVF = 2;
    localparam int EV_COUNT = 3;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;

    // Expands the four byte selects into a 32-bit lane mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

endpackage : irq_ctrl_pkg

// ### logic/level_sync.sv
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ns
module level_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= async_i;
            stage2_q <= stage1_q;
        end
    end

    assign sync_o = stage2_q;

endmodule : level_sync

// ### logic/irq_fiq_ctrl.sv
// Interrupt controller routing sources to normal and fast requests over a Wishbone slave.
`timescale 1ns/1ns
module irq_fiq_ctrl #(
    parameter int NEST_MAX = irq_ctrl_pkg::NEST_LEVELS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [irq_ctrl_pkg::ONCHIP_COUNT-1:0] periph_req_i,
    input wire logic [irq_ctrl_pkg::PIN_COUNT-1:0] ext_pin_i,
    input wire logic irq_enter_i,
    input wire logic irq_leave_i,
    output logic irq_o,
    output logic fiq_o,
    output logic event_irq_o
);

    // ------------------------------------------------------------------
    // Source collection
    // ------------------------------------------------------------------
    logic [irq_ctrl_pkg::PIN_COUNT-1:0] pin_sync;
    logic [31:0] src_d;
    logic [31:0] norm_raw_d;
    logic [31:0] fast_raw_d;
    logic [31:0] norm_sta_d;
    logic [31:0] fast_sta_d;
    logic fast_or_d;
    logic [31:0] norm_raw_q;
    logic [31:0] fast_raw_q;
    logic [31:0] norm_sta_q;
    logic [31:0] fast_sta_q;
    logic [31:0] norm_en_q;
    logic [31:0] fast_en_q;
    logic [31:0] swi_q;
    logic [31:0] vctl_q;
    logic [3:0] nest_q;
    logic [irq_ctrl_pkg::EV_COUNT-1:0] ev_sta_q;
    logic [irq_ctrl_pkg::EV_COUNT-1:0] ev_mask_q;
    logic irq_q;
    logic fiq_q;
    logic ev_irq_q;
    logic ack_q;
    logic [31:0] dat_q;

    level_sync #(
        .WIDTH(irq_ctrl_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(ext_pin_i),
        .sync_o(pin_sync)
    );

    always_comb begin
        src_d = irq_ctrl_pkg::ZERO_WORD;
        for (int i = 0; i < irq_ctrl_pkg::ONCHIP_COUNT; i++) begin
            src_d[irq_ctrl_pkg::ONCHIP_BIT[i]] = periph_req_i[i]; // R1
        end
        for (int i = 0; i < irq_ctrl_pkg::PIN_COUNT; i++) begin
            src_d[irq_ctrl_pkg::PIN_BIT[i]] = pin_sync[i]; // R3
        end
    end

    always_comb begin
        fast_raw_d = src_d; // R12
        fast_raw_d[irq_ctrl_pkg::SWI_BIT] = swi_q[irq_ctrl_pkg::SWI_FAST_POS]; // R15
        fast_raw_d[irq_ctrl_pkg::FAST_OR_BIT] = 1'b0; // R2
        fast_sta_d = fast_raw_d & fast_en_q; // R9
        fast_or_d = |fast_sta_d[31:1]; // R10
        fast_raw_d[irq_ctrl_pkg::FAST_OR_BIT] = fast_or_d; // R10
        fast_sta_d[irq_ctrl_pkg::FAST_OR_BIT] = fast_or_d & fast_en_q[irq_ctrl_pkg::FAST_OR_BIT];
        norm_raw_d = src_d; // R6
        norm_raw_d[irq_ctrl_pkg::SWI_BIT] = swi_q[irq_ctrl_pkg::SWI_NORM_POS]; // R15
        norm_raw_d[irq_ctrl_pkg::FAST_OR_BIT] = fast_or_d; // R10
        norm_sta_d = norm_raw_d & norm_en_q; // R4
    end

    // Raw and status words are registered, one edge after any change.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            norm_raw_q <= irq_ctrl_pkg::ZERO_WORD;
            fast_raw_q <= irq_ctrl_pkg::ZERO_WORD;
            norm_sta_q <= irq_ctrl_pkg::ZERO_WORD;
            fast_sta_q <= irq_ctrl_pkg::ZERO_WORD;
        end else begin
            norm_raw_q <= norm_raw_d & irq_ctrl_pkg::USED_MASK; // R18
            fast_raw_q <= fast_raw_d & irq_ctrl_pkg::USED_MASK; // R18
            norm_sta_q <= norm_sta_d & irq_ctrl_pkg::USED_MASK; // R18
            fast_sta_q <= fast_sta_d & irq_ctrl_pkg::USED_MASK; // R18
        end
    end

    // Requests to the core; no encoder, software reads the status words.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
            fiq_q <= 1'b0;
        end else begin
            irq_q <= |norm_sta_d; // R4 R5
            fiq_q <= fast_or_d; // R10
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic access;
    logic wr;
    logic [31:0] wmask;

    assign access = cyc_i && stb_i && !ack_q;
    assign wr = access && we_i;
    assign wmask = dat_i & irq_ctrl_pkg::lane_mask(sel_i) & irq_ctrl_pkg::USED_MASK;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= irq_ctrl_pkg::ZERO_WORD;
        end else if (access && !we_i) begin
            unique case (adr_i)
                irq_ctrl_pkg::NORM_STATUS_ADR: dat_q <= norm_sta_q;
                irq_ctrl_pkg::NORM_RAW_ADR: dat_q <= norm_raw_q;
                irq_ctrl_pkg::NORM_ENABLE_ADR: dat_q <= norm_en_q;
                irq_ctrl_pkg::FAST_STATUS_ADR: dat_q <= fast_sta_q;
                irq_ctrl_pkg::FAST_RAW_ADR: dat_q <= fast_raw_q;
                irq_ctrl_pkg::FAST_ENABLE_ADR: dat_q <= fast_en_q;
                irq_ctrl_pkg::SWI_CONFIG_ADR: dat_q <= swi_q;
                irq_ctrl_pkg::VEC_CONTROL_ADR: begin
                    dat_q <= vctl_q | {20'h00000, nest_q, 8'h00};
                end
                irq_ctrl_pkg::EVENT_STATUS_ADR: dat_q <= {29'h0, ev_sta_q};
                irq_ctrl_pkg::EVENT_MASK_ADR: dat_q <= {29'h0, ev_mask_q};
                default: dat_q <= irq_ctrl_pkg::ZERO_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            norm_en_q <= irq_ctrl_pkg::ZERO_WORD;
        end else if (wr && adr_i == irq_ctrl_pkg::NORM_ENABLE_ADR) begin
            norm_en_q <= norm_en_q | wmask; // R7
        end else if (wr && adr_i == irq_ctrl_pkg::NORM_CLEAR_ADR) begin
            norm_en_q <= norm_en_q & ~wmask; // R8
        end else if (wr && adr_i == irq_ctrl_pkg::FAST_ENABLE_ADR) begin
            norm_en_q <= norm_en_q & ~wmask; // R11
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_en_q <= irq_ctrl_pkg::ZERO_WORD;
        end else if (wr && adr_i == irq_ctrl_pkg::FAST_ENABLE_ADR) begin
            fast_en_q <= fast_en_q | wmask; // R9
        end else if (wr && adr_i == irq_ctrl_pkg::FAST_CLEAR_ADR) begin
            fast_en_q <= fast_en_q & ~wmask; // R16
        end else if (wr && adr_i == irq_ctrl_pkg::NORM_ENABLE_ADR) begin
            fast_en_q <= fast_en_q & ~wmask; // R11
        end
    end

    // ------------------------------------------------------------------
    // Software interrupt and vectored control
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swi_q <= irq_ctrl_pkg::ZERO_WORD;
        end else if (wr && adr_i == irq_ctrl_pkg::SWI_CONFIG_ADR) begin
            swi_q <= (swi_q & ~irq_ctrl_pkg::lane_mask(sel_i)) | (wmask & irq_ctrl_pkg::SWI_MASK); // R15
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vctl_q <= irq_ctrl_pkg::ZERO_WORD;
        end else if (wr && adr_i == irq_ctrl_pkg::VEC_CONTROL_ADR) begin
            vctl_q <= (vctl_q & ~irq_ctrl_pkg::lane_mask(sel_i)) | (wmask & irq_ctrl_pkg::VEC_CTL_MASK);
        end
    end

    // Depth of entered normal handlers; only one level without nesting.
    logic nest_en;
    logic nest_full;

    assign nest_en = vctl_q[irq_ctrl_pkg::NEST_EN_POS];
    assign nest_full = nest_en ? (nest_q == 4'(NEST_MAX)) : (nest_q != 4'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nest_q <= irq_ctrl_pkg::NEST_RESET;
        end else if (irq_enter_i && !irq_leave_i && !nest_full) begin
            nest_q <= nest_q + 4'h1; // R13
        end else if (irq_leave_i && !irq_enter_i && nest_q != 4'h0) begin
            nest_q <= nest_q - 4'h1; // R13
        end
    end

    // ------------------------------------------------------------------
    // Event status and interrupt
    // ------------------------------------------------------------------
    logic [irq_ctrl_pkg::EV_COUNT-1:0] ev_set;
    logic [irq_ctrl_pkg::EV_COUNT-1:0] ev_clr;

    always_comb begin
        ev_set = '0;
        ev_set[irq_ctrl_pkg::EV_NORM_RISE] = |norm_sta_d && !irq_q;
        ev_set[irq_ctrl_pkg::EV_FAST_RISE] = fast_or_d && !fiq_q;
        ev_set[irq_ctrl_pkg::EV_NEST_OVF] = irq_enter_i && !irq_leave_i && nest_full;
        ev_clr = '0;
        if (wr && adr_i == irq_ctrl_pkg::EVENT_STATUS_ADR) begin
            ev_clr = wmask[irq_ctrl_pkg::EV_COUNT-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_sta_q <= '0;
        end else begin
            ev_sta_q <= (ev_sta_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_mask_q <= '0;
        end else if (wr && adr_i == irq_ctrl_pkg::EVENT_MASK_ADR) begin
            ev_mask_q <= wmask[irq_ctrl_pkg::EV_COUNT-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_irq_q <= 1'b0;
        end else begin
            ev_irq_q <= |(((ev_sta_q & ~ev_clr) | ev_set) & ev_mask_q);
        end
    end

    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign irq_o = irq_q;
    assign fiq_o = fiq_q;
    assign event_irq_o = ev_irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence norm_set_s;
        wr && adr_i == irq_ctrl_pkg::NORM_ENABLE_ADR && wmask != 32'h00000000;
    endsequence

    sequence fast_set_s;
        wr && adr_i == irq_ctrl_pkg::FAST_ENABLE_ADR && wmask != 32'h00000000;
    endsequence

    norm_status_and_a: assert property (norm_sta_q == (norm_raw_q & norm_en_q) || $changed(norm_en_q)) // R4
        else $error("Normal status differs from raw and enable.");
    irq_follows_status_a: assert property ($rose(|norm_sta_q) |-> irq_o) // R4
        else $error("Normal request missing while status is set.");
    unused_zero_a: assert property ((norm_sta_q | fast_sta_q | norm_en_q | fast_en_q) <= 32'h003fffff) // R18
        else $error("Unused source bits are set.");
    enable_sets_a: assert property (norm_set_s |=> ((norm_en_q & $past(wmask)) == $past(wmask))) // R7
        else $error("Normal enable write did not set bits.");
    clear_clears_a: assert property (wr && adr_i == irq_ctrl_pkg::NORM_CLEAR_ADR
        |=> (norm_en_q == ($past(norm_en_q) & ~$past(wmask)))) // R8
        else $error("Normal mask clear wrong.");
    fast_clear_a: assert property (wr && adr_i == irq_ctrl_pkg::FAST_CLEAR_ADR
        |=> (fast_en_q == ($past(fast_en_q) & ~$past(wmask)))) // R16
        else $error("Fast mask clear wrong.");
    masks_exclusive_a: assert property (fast_set_s |=> ((norm_en_q & $past(wmask)) == 32'h00000000)) // R11
        else $error("Fast enable did not clear normal enable.");
    fiq_or_feedback_a: assert property ((|fast_sta_q[31:1]) == fiq_o
        && norm_raw_q[0] == fiq_o && fast_raw_q[0] == fiq_o) // R10
        else $error("Fast OR feedback mismatch.");
    swi_drives_raw_a: assert property ($rose(swi_q[1]) |=> norm_raw_q[1]) // R15
        else $error("Software interrupt not visible in raw word.");
    nest_bound_a: assert property (nest_q <= 4'(NEST_MAX)) // R13
        else $error("Nesting depth out of range.");
    nest_single_a: assert property (!nest_en && !$past(nest_en) && $past(nest_q) <= 4'h1 |-> nest_q <= 4'h1) // R13
        else $error("Nesting depth above one without nesting.");
    bus_ack_once_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("Bus acknowledge not a single cycle.");

endmodule : irq_fiq_ctrl

// ### sim/src_model.sv
// Behavioural model of the peripheral and external pin request sources.
`timescale 1ns/1ns
module src_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] set_i,
    input wire logic [15:0] clr_i,
    input wire logic [3:0] pin_set_i,
    input wire logic [3:0] pin_clr_i,
    output logic [15:0] periph_req_o,
    output logic [3:0] ext_pin_o
);
    // ------------------------------------------------------------------
    // Request levels
    // ------------------------------------------------------------------
    // A request stays up until its source clears it, so it outlasts the capture latency.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_req_o <= 16'h0000;
            ext_pin_o <= 4'h0;
        end else begin
            periph_req_o <= (periph_req_o | set_i) & ~clr_i;
            ext_pin_o <= (ext_pin_o | pin_set_i) & ~pin_clr_i;
        end
    end
endmodule : src_model

// ### sim/tb.sv
// Self-checking testbench for the interrupt controller.
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [31:0] adr_i = 32'h00000000;
    logic [31:0] dat_i = 32'h00000000;
    logic [3:0] sel_i = 4'hf;
    logic [15:0] pset = 16'h0000;
    logic [15:0] pclr = 16'h0000;
    logic [3:0] nset = 4'h0;
    logic [3:0] nclr = 4'h0;
    logic irq_enter_i = 1'b0;
    logic irq_leave_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, irq_o, fiq_o, event_irq_o;
    logic [15:0] periph_req;
    logic [3:0] ext_pin;
    int n_errors = 0;
    int n_checks = 0;
    logic [31:0] rnd = 32'hc682;
    logic [31:0] expq[$];
    logic rdq[$];
    logic [15:0] per = 16'h0000;
    logic [3:0] pin = 4'h0;
    logic [31:0] nen = 32'h00000000;
    logic [31:0] fen = 32'h00000000;
    logic [31:0] rn, rf, sw, r;
    logic fq;

    always #10 clk_i = ~clk_i;

    src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .set_i(pset), .clr_i(pclr), .pin_set_i(nset),
        .pin_clr_i(nclr), .periph_req_o(periph_req), .ext_pin_o(ext_pin));

    irq_fiq_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .periph_req_i(periph_req),
        .ext_pin_i(ext_pin), .irq_enter_i(irq_enter_i), .irq_leave_i(irq_leave_i), .irq_o(irq_o),
        .fiq_o(fiq_o), .event_irq_o(event_irq_o));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [31:0] srcw(input logic [15:0] p, input logic [3:0] q);
        logic [31:0] w;
        w = 32'h00000000;
        for (int k = 0; k < irq_ctrl_pkg::ONCHIP_COUNT; k++) w[irq_ctrl_pkg::ONCHIP_BIT[k]] = p[k];
        for (int k = 0; k < irq_ctrl_pkg::PIN_COUNT; k++) w[irq_ctrl_pkg::PIN_BIT[k]] = q[k];
        return w;
    endfunction : srcw

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        rdq.push_back(!w);
        expq.push_back(e);
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            final_report();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle

    task automatic src(input logic [15:0] s, input logic [15:0] c, input logic [3:0] ps, input logic [3:0] pc);
        @(posedge clk_i);
        pset <= s;
        pclr <= c;
        nset <= ps;
        nclr <= pc;
        @(posedge clk_i);
        pset <= 16'h0000;
        pclr <= 16'h0000;
        nset <= 4'h0;
        nclr <= 4'h0;
        per = (per | s) & ~c;
        pin = (pin | ps) & ~pc;
        settle();
    endtask : src

    task automatic pulse(input logic ent);
        @(posedge clk_i);
        irq_enter_i <= ent;
        irq_leave_i <= !ent;
        @(posedge clk_i);
        irq_enter_i <= 1'b0;
        irq_leave_i <= 1'b0;
    endtask : pulse

    task automatic verify;
        rn = srcw(per, pin) | {30'h0, sw[1], 1'b0};
        rf = srcw(per, pin) | {30'h0, sw[2], 1'b0};
        fq = |(rf[31:1] & fen[31:1]);
        rn[0] = fq;
        rf[0] = fq;
        wb(1'b0, irq_ctrl_pkg::NORM_RAW_ADR, 0, rn);
        wb(1'b0, irq_ctrl_pkg::FAST_RAW_ADR, 0, rf);
        wb(1'b0, irq_ctrl_pkg::NORM_STATUS_ADR, 0, rn & nen);
        wb(1'b0, irq_ctrl_pkg::FAST_STATUS_ADR, 0, rf & fen);
        wb(1'b0, irq_ctrl_pkg::NORM_ENABLE_ADR, 0, nen);
        wb(1'b0, irq_ctrl_pkg::FAST_ENABLE_ADR, 0, fen);
        wb(1'b0, irq_ctrl_pkg::NORM_CLEAR_ADR, 0, 32'h00000000);
        settle();
        check({31'h0, irq_o}, {31'h0, |(rn & nen)});
        check({31'h0, fiq_o}, {31'h0, fq});
    endtask : verify

    // ------------------------------------------------------------------
    // Read monitor
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (ack_o === 1'b1) begin
            if (rdq.size() == 0) begin
                check(32'h00000001, 32'h00000000);
            end else if (rdq.pop_front()) begin
                check(dat_o, expq.pop_front());
            end else begin
                void'(expq.pop_front());
            end
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sw = 32'h00000000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 12; a++) wb(1'b0, 32'hffff0000 + a * 4, 0, 32'h00000000);
        for (int a = 0; a < 8; a++) wb(1'b0, 32'hffff0100 + a * 4, 0, 32'h00000000);
        for (int t = 0; t < 12; t++) begin
            rnd = xs(rnd);
            src(rnd[15:0], rnd[31:16] & rnd[23:8], rnd[3:0], rnd[7:4]);
            rnd = xs(rnd);
            r = rnd & irq_ctrl_pkg::USED_MASK;
            wb(1'b1, irq_ctrl_pkg::NORM_ENABLE_ADR, rnd, 0);
            nen = nen | r;
            fen = fen & ~r;
            rnd = xs(rnd);
            r = rnd & irq_ctrl_pkg::USED_MASK;
            wb(1'b1, irq_ctrl_pkg::FAST_ENABLE_ADR, rnd, 0);
            fen = fen | r;
            nen = nen & ~r;
            rnd = xs(rnd);
            wb(1'b1, irq_ctrl_pkg::NORM_CLEAR_ADR, rnd & xs(rnd), 0);
            nen = nen & ~(rnd & xs(rnd));
            rnd = xs(rnd);
            wb(1'b1, irq_ctrl_pkg::FAST_CLEAR_ADR, rnd & xs(rnd), 0);
            fen = fen & ~(rnd & xs(rnd));
            wb(1'b1, irq_ctrl_pkg::NORM_RAW_ADR, 32'hffffffff, 0);
            wb(1'b1, irq_ctrl_pkg::FAST_STATUS_ADR, 32'hffffffff, 0);
            sw = rnd & irq_ctrl_pkg::SWI_MASK;
            wb(1'b1, irq_ctrl_pkg::SWI_CONFIG_ADR, rnd, 0);
            wb(1'b0, irq_ctrl_pkg::SWI_CONFIG_ADR, 0, sw);
            verify();
        end
        wb(1'b1, irq_ctrl_pkg::NORM_CLEAR_ADR, 32'hffffffff, 0);
        wb(1'b1, irq_ctrl_pkg::FAST_CLEAR_ADR, 32'hffffffff, 0);
        wb(1'b1, irq_ctrl_pkg::SWI_CONFIG_ADR, 0, 0);
        src(16'h0000, 16'hffff, 4'h0, 4'hf);
        sel_i <= 4'h2;
        wb(1'b1, irq_ctrl_pkg::NORM_ENABLE_ADR, 32'h00ffff00, 0);
        sel_i <= 4'hf;
        wb(1'b0, irq_ctrl_pkg::NORM_ENABLE_ADR, 0, 32'h0000ff00);
        wb(1'b1, irq_ctrl_pkg::EVENT_STATUS_ADR, 32'h00000007, 0);
        wb(1'b1, irq_ctrl_pkg::EVENT_MASK_ADR, 32'h00000001, 0);
        wb(1'b0, irq_ctrl_pkg::EVENT_STATUS_ADR, 0, 32'h00000000);
        check({31'h0, event_irq_o}, 32'h00000000);
        src(16'h0001, 16'h0000, 4'h0, 4'h0);
        wb(1'b1, irq_ctrl_pkg::NORM_ENABLE_ADR, 32'h00000004, 0);
        settle();
        check({31'h0, irq_o}, 32'h00000001);
        wb(1'b0, irq_ctrl_pkg::EVENT_STATUS_ADR, 0, 32'h00000001);
        check({31'h0, event_irq_o}, 32'h00000001);
        wb(1'b1, irq_ctrl_pkg::EVENT_MASK_ADR, 32'h00000000, 0);
        settle();
        check({31'h0, event_irq_o}, 32'h00000000);
        wb(1'b1, irq_ctrl_pkg::EVENT_MASK_ADR, 32'h00000001, 0);
        settle();
        check({31'h0, event_irq_o}, 32'h00000001);
        wb(1'b1, irq_ctrl_pkg::EVENT_STATUS_ADR, 32'h00000001, 0);
        settle();
        check({31'h0, event_irq_o}, 32'h00000000);
        pulse(1'b1);
        pulse(1'b1);
        wb(1'b0, irq_ctrl_pkg::VEC_CONTROL_ADR, 0, 32'h00000100);
        wb(1'b0, irq_ctrl_pkg::EVENT_STATUS_ADR, 0, 32'h00000004);
        wb(1'b1, irq_ctrl_pkg::VEC_CONTROL_ADR, 32'h00000001, 0);
        pulse(1'b1);
        wb(1'b0, irq_ctrl_pkg::VEC_CONTROL_ADR, 0, 32'h00000201);
        pulse(1'b0);
        wb(1'b0, irq_ctrl_pkg::VEC_CONTROL_ADR, 0, 32'h00000101);
        settle();
        final_report();
    end
endmodule : tb
